// file: hdl/fan_pwm_and_tach_monitor.sv
// fan pwm generator and tachometer period monitor with apb registers
//
// Chosen here: register access over APB.
`timescale 1ns/1ns

module fan_pwm_and_tach_monitor #(
    parameter int DIV_40HZ  = fan_pwm_pkg::DIV_40,   // 40 hz tick divider
    parameter int DIV_60HZ  = fan_pwm_pkg::DIV_60,   // 60 hz tick divider
    parameter int DIV_80HZ  = fan_pwm_pkg::DIV_80,   // 80 hz tick divider
    parameter int DIV_120HZ = fan_pwm_pkg::DIV_120   // 120 hz divider
) (
    input  wire logic        ref_clk,
    input  wire logic        rstn,
    input  wire logic [11:0] paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        slowClockPin,
    input  wire logic        tachInput,
    output logic             fanPwm,
    output logic             wakeEventOut,
    output logic             mgmtInterruptOut,
    output logic             irq
);

    // ***********************************************************
    // registers written by software, and the hardware-set sticky status
    // ***********************************************************
    logic [7:0] dutyReg;      // fan_duty_setting
    logic [7:0] ctrlReg;      // fan_control_setting
    logic [7:0] preloadReg;   // tach preload
    logic       extSlowSel;   // ext_slow_clock_present
    logic [1:0] irqEnable;    // event interrupt enable
    logic [1:0] eventEnable;  // wake and mgmt enables
    logic [1:0] status;       // sticky event status

    // ***********************************************************
    // apb decode
    // ***********************************************************
    wire        setupPhase = psel & ~penable;       // first cycle
    wire        accessDone = psel & penable & pready;
    wire        wrStrobe   = accessDone & pwrite;
    wire        hitDuty    = paddr == fan_pwm_pkg::ADDR_DUTY;
    wire        hitCtrl    = paddr == fan_pwm_pkg::ADDR_CTRL;
    wire        hitPreload = paddr == fan_pwm_pkg::ADDR_PRELOAD;
    wire        hitCount   = paddr == fan_pwm_pkg::ADDR_COUNT;
    wire        hitSlowCfg = paddr == fan_pwm_pkg::ADDR_SLOWCFG;
    wire        hitStatus  = paddr == fan_pwm_pkg::ADDR_STATUS;
    wire        hitClear   = paddr == fan_pwm_pkg::ADDR_CLEAR;
    wire        hitIrqEn   = paddr == fan_pwm_pkg::ADDR_IRQEN;
    wire        hitEvEn    = paddr == fan_pwm_pkg::ADDR_EVEN;
    // any mapped word; the clear register reads as zero
    wire        hitAny     = hitDuty | hitCtrl | hitPreload | hitCount
                           | hitSlowCfg | hitStatus | hitClear
                           | hitIrqEn | hitEvEn;
    wire        wrPreload  = wrStrobe & hitPreload;
    wire [1:0]  clearBits  = (wrStrobe & hitClear) ? pwdata[1:0] : 2'h0;

    logic [7:0] tachCount;    // running tach count
    wire [31:0] readData =
          hitDuty    ? {24'h00_0000, dutyReg}
        : hitCtrl    ? {24'h00_0000, ctrlReg}
        : hitPreload ? {24'h00_0000, preloadReg}
        : hitCount   ? {24'h00_0000, tachCount}
        : hitSlowCfg ? {31'h0000_0000, extSlowSel}
        : hitStatus  ? {30'h0000_0000, status}
        : hitIrqEn   ? {30'h0000_0000, irqEnable}
        : hitEvEn    ? {30'h0000_0000, eventEnable}
        : 32'h0000_0000;

    // answer one cycle after setup: zero wait states, data from flops
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            pready  <= setupPhase;
            pslverr <= setupPhase & ~hitAny;   // unmapped word
            prdata  <= setupPhase ? readData : 32'h0000_0000;
        end
    end

    // register writes land at the access edge only
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            dutyReg     <= fan_pwm_pkg::DUTY_RST;
            ctrlReg     <= fan_pwm_pkg::CTRL_RST;
            preloadReg  <= fan_pwm_pkg::PRELOAD_RST;
            extSlowSel  <= 1'b0;
            irqEnable   <= 2'h0;
            eventEnable <= 2'h0;
        end else if (wrStrobe) begin
            if (hitDuty)    dutyReg     <= pwdata[7:0];
            if (hitCtrl)    ctrlReg     <= pwdata[7:0];
            if (hitPreload) preloadReg  <= pwdata[7:0];
            if (hitSlowCfg) extSlowSel  <= pwdata[0];
            if (hitIrqEn)   irqEnable   <= pwdata[1:0];
            if (hitEvEn)    eventEnable <= pwdata[1:0];
        end
    end

    // ***********************************************************
    // pwm frequency selection
    // ***********************************************************
    // field pick-off from the two fan registers
    wire       forceHigh = dutyReg[fan_pwm_pkg::DUTY_FORCE_BIT];
    wire [5:0] dutyLevel =
        dutyReg[fan_pwm_pkg::DUTY_MSB:fan_pwm_pkg::DUTY_LSB];
    wire       clkSel    = dutyReg[fan_pwm_pkg::DUTY_CSEL_BIT];
    wire       srcSel    = ctrlReg[fan_pwm_pkg::CTRL_SRC_BIT];
    wire       mult      = ctrlReg[fan_pwm_pkg::CTRL_MULT_BIT];
    wire [1:0] divCode   =
        ctrlReg[fan_pwm_pkg::CTRL_DIV_MSB:fan_pwm_pkg::CTRL_DIV_LSB];

    // cycles of ref_clk per pwm tick; 64 ticks make one period
    wire [15:0] baseDiv = srcSel
        ? (clkSel ? 16'(DIV_60HZ) : 16'(DIV_40HZ))
        : (clkSel ? 16'(fan_pwm_pkg::DIV_23K)
                  : 16'(fan_pwm_pkg::DIV_15K));
    wire [15:0] fastDiv = srcSel
        ? (clkSel ? 16'(DIV_120HZ) : 16'(DIV_80HZ))
        : (clkSel ? 16'(fan_pwm_pkg::DIV_46K)
                  : 16'(fan_pwm_pkg::DIV_31K));
    wire [15:0] tickDiv = mult ? fastDiv : baseDiv;

    logic [15:0] preCnt;      // ref_clk cycles within one tick
    logic [5:0]  phase;       // tick index within the period
    // >= rather than == so a shorter divider takes effect at once
    wire         pwmTick = preCnt >= (tickDiv - 16'h0001);

    // tick prescaler and 64-step phase counter
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            preCnt <= 16'h0000;
            phase  <= 6'h00;
        end else begin
            preCnt <= pwmTick ? 16'h0000 : preCnt + 16'h0001;
            if (pwmTick) phase <= phase + 6'h01;
        end
    end

    // ***********************************************************
    // pwm output
    // ***********************************************************
    // high for the first dutyLevel ticks; level zero never matches
    wire next_fanPwm = forceHigh
                     | (phase < dutyLevel);

    always_ff @(posedge ref_clk) begin
        if (!rstn) fanPwm <= 1'b0;
        else       fanPwm <= next_fanPwm;
    end

    // ***********************************************************
    // slow counting clock
    // ***********************************************************
    // pin is asynchronous: two flops before any logic looks at it
    logic [1:0] slowSync;     // slowSync[0] feeds slowSync[1] only
    logic       slowPrev;     // previous synchronised level
    logic [15:0] intCnt;      // internal 32 khz divider
    wire        extRise  = slowSync[1] & ~slowPrev;
    wire        intTick  = intCnt == 16'(fan_pwm_pkg::DIV_SLOW - 1);
    wire        slowTick = extSlowSel ? extRise : intTick;

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            slowSync <= 2'h0;
            slowPrev <= 1'b0;
            intCnt   <= 16'h0000;
        end else begin
            slowSync <= {slowSync[0], slowClockPin};
            slowPrev <= slowSync[1];
            intCnt   <= intTick ? 16'h0000 : intCnt + 16'h0001;
        end
    end

    // divide slow ticks by 1, 2, 4 or 8
    logic [2:0] divCnt;       // slow ticks, free-running modulo 8
    wire  [2:0] divMask = (3'h1 << divCode) - 3'h1;
    wire        divTick = slowTick
                        & ((divCnt & divMask) == divMask);

    always_ff @(posedge ref_clk) begin
        if (!rstn)         divCnt <= 3'h0;
        else if (slowTick) divCnt <= divCnt + 3'h1;
    end

    // ***********************************************************
    // tachometer period counter
    // ***********************************************************
    logic [1:0] tachSync;     // tachSync[0] feeds tachSync[1] only
    logic       tachPrev;     // previous synchronised tach level
    wire        tachRise = tachSync[1] & ~tachPrev;
    wire        restart  = tachRise | wrPreload;
    wire        atMax    = tachCount == fan_pwm_pkg::COUNT_MAX;
    // a preload write counts from the value being written
    wire  [7:0] loadVal  = wrPreload ? pwdata[7:0] : preloadReg;

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            // the tach line idles high at its pull-up: start the
            // synchroniser high so release gives no false rising edge
            tachSync  <= 2'h3;
            tachPrev  <= 1'b1;
            tachCount <= fan_pwm_pkg::PRELOAD_RST;
        end else begin
            tachSync <= {tachSync[0], tachInput};
            tachPrev <= tachSync[1];
            if (restart)
                tachCount <= loadVal;
            else if (divTick && !atMax)
                tachCount <= tachCount + 8'h01;
        end
    end

    // ***********************************************************
    // events, status and interrupt outputs
    // ***********************************************************
    // top two bits both set means the count has reached 192
    wire       alarmNow = tachCount[7:6] == fan_pwm_pkg::ALARM_MSBS;
    logic      alarmPrev; // level one cycle back, for edge detect
    logic      satPrev;
    wire [1:0] setBits  = {atMax & ~satPrev,
                           alarmNow & ~alarmPrev};
    // a set in the same cycle as a clear still lands
    wire [1:0] next_status = (status & ~clearBits) | setBits;
    wire       alarmSts    = next_status[fan_pwm_pkg::STS_ALARM_BIT];

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            status           <= 2'h0;
            alarmPrev        <= 1'b0;
            satPrev          <= 1'b0;
            wakeEventOut     <= 1'b0;
            mgmtInterruptOut <= 1'b0;
            irq              <= 1'b0;
        end else begin
            status    <= next_status;
            alarmPrev <= alarmNow;
            satPrev   <= atMax;
            wakeEventOut <= alarmSts
                & eventEnable[fan_pwm_pkg::EVEN_WAKE_BIT];
            mgmtInterruptOut <= alarmSts
                & eventEnable[fan_pwm_pkg::EVEN_MGMT_BIT];
            irq <= |(next_status & irqEnable);
        end
    end

    // ***********************************************************
    // checks
    // ***********************************************************
    a_pwm_force_high: assert property (
        @(posedge ref_clk) disable iff (!rstn)
        forceHigh |=> fanPwm)
        else $error("pwm not high while forced");

    a_pwm_zero_low: assert property (
        @(posedge ref_clk) disable iff (!rstn)
        (!forceHigh && dutyLevel == 6'h00) |=> !fanPwm)
        else $error("pwm high with zero duty");

    a_pwm_duty_phase: assert property (
        @(posedge ref_clk) disable iff (!rstn)
        !forceHigh |=> fanPwm == ($past(phase) < $past(dutyLevel)))
        else $error("pwm level disagrees with phase");

    a_tach_restart_load: assert property (
        @(posedge ref_clk) disable iff (!rstn)
        tachRise && !wrPreload |=> tachCount == $past(preloadReg))
        else $error("tach count not reloaded");

    a_tach_saturate: assert property (
        @(posedge ref_clk) disable iff (!rstn)
        atMax && !restart |=> tachCount == 8'hFF)
        else $error("tach count wrapped");

    a_tach_tick_only: assert property (
        @(posedge ref_clk) disable iff (!rstn)
        !restart && !divTick |=> $stable(tachCount))
        else $error("tach count moved without tick");

    a_alarm_sticky: assert property (
        @(posedge ref_clk) disable iff (!rstn)
        (alarmNow && !alarmPrev) |=> status[0]
            && wakeEventOut == $past(eventEnable[0]))
        else $error("alarm not captured or wake wrong");

    a_div_reset_val: assert property (
        @(posedge ref_clk)
        $past(!rstn) && rstn |-> divCode == 2'b01 && !fanPwm)
        else $error("reset state of divisor or pwm wrong");

endmodule : fan_pwm_and_tach_monitor

// file: hdl/fan_pwm_pkg.sv
// constants shared by the fan pwm and tachometer monitor block
package fan_pwm_pkg;

    // ***********************************************************
    // clock and bus
    // ***********************************************************
    localparam int CLK_HZ   = 100_000_000;  // ref_clk rate
    localparam int ADDR_W   = 12;           // apb byte address width
    localparam int DATA_W   = 32;           // apb data width

    // ***********************************************************
    // register indices (byte address is four times the index)
    // ***********************************************************
    localparam int IDX_DUTY    = 'h56;   // fan_duty_setting
    localparam int IDX_CTRL    = 'h58;   // fan_control_setting
    localparam int IDX_PRELOAD = 'h5A;   // tach preload
    localparam int IDX_COUNT   = 'h5B;   // tach count, read only
    localparam int IDX_SLOWCFG = 'h5C;   // slow_clock_config
    localparam int IDX_STATUS  = 'h5D;   // event status, read only
    localparam int IDX_CLEAR   = 'h5E;   // event clear, write only
    localparam int IDX_IRQEN   = 'h5F;   // event interrupt enable
    localparam int IDX_EVEN    = 'h60;   // wake and mgmt enables

    localparam logic [11:0] ADDR_DUTY    = 12'(4 * IDX_DUTY);
    localparam logic [11:0] ADDR_CTRL    = 12'(4 * IDX_CTRL);
    localparam logic [11:0] ADDR_PRELOAD = 12'(4 * IDX_PRELOAD);
    localparam logic [11:0] ADDR_COUNT   = 12'(4 * IDX_COUNT);
    localparam logic [11:0] ADDR_SLOWCFG = 12'(4 * IDX_SLOWCFG);
    localparam logic [11:0] ADDR_STATUS  = 12'(4 * IDX_STATUS);
    localparam logic [11:0] ADDR_CLEAR   = 12'(4 * IDX_CLEAR);
    localparam logic [11:0] ADDR_IRQEN   = 12'(4 * IDX_IRQEN);
    localparam logic [11:0] ADDR_EVEN    = 12'(4 * IDX_EVEN);

    // ***********************************************************
    // field positions and reset values
    // ***********************************************************
    localparam int DUTY_FORCE_BIT = 0;   // clock control, force high
    localparam int DUTY_LSB       = 1;   // duty_level low bit
    localparam int DUTY_MSB       = 6;   // duty_level high bit
    localparam int DUTY_CSEL_BIT  = 7;   // clock select
    localparam int CTRL_SRC_BIT   = 0;   // clock source select
    localparam int CTRL_MULT_BIT  = 2;   // clock multiplier
    localparam int CTRL_DIV_LSB   = 4;   // count divisor low bit
    localparam int CTRL_DIV_MSB   = 5;   // count divisor high bit
    localparam int STS_ALARM_BIT  = 0;   // count reached 192
    localparam int STS_SAT_BIT    = 1;   // count saturated at 255
    localparam int EVEN_WAKE_BIT  = 0;   // wake_enable_group1
    localparam int EVEN_MGMT_BIT  = 1;   // mgmt_int_enable_group4

    localparam logic [7:0] DUTY_RST    = 8'h00;   // pwm pin low
    localparam logic [7:0] CTRL_RST    = 8'h10;   // divisor code 01
    localparam logic [7:0] PRELOAD_RST = 8'h00;
    localparam logic [7:0] COUNT_MAX   = 8'hFF;   // saturating top
    localparam logic [1:0] ALARM_MSBS  = 2'b11;   // count of 192

    // ***********************************************************
    // pwm frequencies in hz and derived tick dividers
    // ***********************************************************
    localparam int PWM_STEPS = 64;       // ticks per pwm period
    localparam int F_15K = 15625;
    localparam int F_23K = 23438;
    localparam int F_40  = 40;
    localparam int F_60  = 60;
    localparam int DIV_15K = (CLK_HZ + 32 * F_15K) / (64 * F_15K);
    localparam int DIV_23K = (CLK_HZ + 32 * F_23K) / (64 * F_23K);
    localparam int DIV_31K = (CLK_HZ + 64 * F_15K) / (128 * F_15K);
    localparam int DIV_46K = (CLK_HZ + 64 * F_23K) / (128 * F_23K);
    localparam int DIV_40  = (CLK_HZ + 32 * F_40) / (64 * F_40);
    localparam int DIV_60  = (CLK_HZ + 32 * F_60) / (64 * F_60);
    localparam int DIV_80  = (CLK_HZ + 64 * F_40) / (128 * F_40);
    localparam int DIV_120 = (CLK_HZ + 64 * F_60) / (128 * F_60);

    // internal slow clock, 32.768 khz made from ref_clk
    localparam int F_SLOW   = 32768;
    localparam int DIV_SLOW = (CLK_HZ + F_SLOW / 2) / F_SLOW;

endpackage : fan_pwm_pkg

// file: dv/fan_model.sv
// behavioural cooling fan: tachometer pulses while the rotor spins
`timescale 1ns/1ns

module fan_model (
    input  wire logic        refClk,
    input  wire logic        spin,
    input  wire logic [15:0] halfPeriod,
    output logic             tach
);
    // ***********************************************************
    // rotation
    // ***********************************************************
    logic [15:0] phase;   // cycles into the current half turn

    initial begin
        phase = 16'h0000;
        tach  = 1'b1;
    end

    // a stalled fan leaves the open-collector tach line at its pull-up,
    // so no rising edge appears while stopped
    always @(posedge refClk) begin
        if (!spin) begin
            phase <= 16'h0000;
            tach  <= 1'b1;
        end else if (phase == halfPeriod - 16'h0001) begin
            phase <= 16'h0000;   // half turn done, flip the tach level
            tach  <= ~tach;
        end else begin
            phase <= phase + 16'h0001;
        end
    end
endmodule : fan_model

// file: dv/tb_top.sv
// self-checking bench for the fan pwm and tachometer monitor
`timescale 1ns/1ns

module tb_top;
    // ***********************************************************
    // signals
    // ***********************************************************
    logic        refClk, rstn, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rdata;
    logic        slowClockPin, tachInput, fanPwm, irq;
    logic        wakeEventOut, mgmtInterruptOut, spin, err;
    logic [15:0] halfPeriod;
    logic [2:0]  slowDiv;         // makes a fast stand-in slow clock
    int          num_errors, samples_checked, cycles;
    int          divs[8] = '{100, 67, 8, 9, 50, 33, 10, 11};

    fan_pwm_and_tach_monitor #(.DIV_40HZ(8), .DIV_60HZ(9), .DIV_80HZ(10),
        .DIV_120HZ(11)) dut_u (.ref_clk(refClk), .rstn(rstn),
        .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .slowClockPin(slowClockPin),
        .tachInput(tachInput), .fanPwm(fanPwm),
        .wakeEventOut(wakeEventOut),
        .mgmtInterruptOut(mgmtInterruptOut), .irq(irq));

    fan_model fan_u (.refClk(refClk), .spin(spin),
        .halfPeriod(halfPeriod), .tach(tachInput));

    // ***********************************************************
    // clock, slow clock pin and watchdog
    // ***********************************************************
    initial begin
        refClk = 1'b0;
        forever #5 refClk = ~refClk;
    end

    // slow clock at an eighth of ref_clk keeps tach counts short
    always @(posedge refClk) begin
        slowDiv      <= slowDiv + 3'h1;
        slowClockPin <= slowDiv[2];
        cycles       <= cycles + 1;
        if (cycles == 90000) begin   // a hang cannot outlive this
            num_errors++;
            results();
        end
    end

    // ***********************************************************
    // shared tasks
    // ***********************************************************
    task automatic check(input string what, input logic [31:0] seen, exp);
        samples_checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic results;
        $display("checks %0d mismatches %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : results

    // one apb transfer; waits for pready, never assumes its delay
    task automatic apb(input logic [11:0] a, input logic w,
                       input logic [31:0] d);
        int n;
        n = 0;
        @(posedge refClk);
        psel <= 1'b1; paddr <= a; pwrite <= w; pwdata <= d;
        @(posedge refClk);
        penable <= 1'b1;
        do begin
            @(posedge refClk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rdata = prdata;
        err   = pslverr;
        if (n >= 50) check("pready", 32'h0, 32'h1);
        psel <= 1'b0; penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(a, 1'b1, d);
    endtask : wr

    task automatic waitCycles(input int n);
        repeat (n) @(posedge refClk);
    endtask : waitCycles

    // measure one full pwm period: high cycles then low cycles
    task automatic measure(output int hi, output int lo);
        int n;
        n = 0; hi = 0; lo = 0;
        while (fanPwm !== 1'b0 && n < 20000) begin
            @(posedge refClk); n++;
        end
        while (fanPwm !== 1'b1 && n < 20000) begin
            @(posedge refClk); n++;
        end
        while (fanPwm === 1'b1 && n < 20000) begin
            @(posedge refClk); n++; hi++;
        end
        while (fanPwm === 1'b0 && n < 20000) begin
            @(posedge refClk); n++; lo++;
        end
    endtask : measure

    // ***********************************************************
    // scenarios
    // ***********************************************************
    task automatic testReset;
        check("pwm after reset", fanPwm, 1'b0);
        apb(fan_pwm_pkg::ADDR_DUTY, 1'b0, 32'h0);
        check("duty reset", rdata, 32'h0000_0000);
        apb(fan_pwm_pkg::ADDR_CTRL, 1'b0, 32'h0);
        check("ctrl reset", rdata, 32'h0000_0010);
        apb(12'h004, 1'b0, 32'h0);
        check("unmapped err", err, 1'b1);
        check("unmapped data", rdata, 32'h0000_0000);
        $display("test reset done");
    endtask : testReset

    task automatic testLevels;
        int hi;
        wr(fan_pwm_pkg::ADDR_DUTY, 32'h0000_0000);
        hi = 0;
        repeat (300) begin @(posedge refClk); hi += int'(fanPwm === 1'b1); end
        check("duty zero high", hi, 0);
        wr(fan_pwm_pkg::ADDR_DUTY, 32'h0000_0001);
        waitCycles(3);
        hi = 0;
        repeat (300) begin @(posedge refClk); hi += int'(fanPwm === 1'b1); end
        check("forced high", hi, 300);
        $display("test levels done");
    endtask : testLevels

    // every source, select and multiplier code at duty 63
    task automatic testModes;
        int hi, lo;
        for (int m = 0; m < 8; m++) begin
            wr(fan_pwm_pkg::ADDR_CTRL, 32'h10 | (m[2] << 2) | m[1]);
            wr(fan_pwm_pkg::ADDR_DUTY, 32'h7E | (m[0] << 7));
            measure(hi, lo);
            check("mode high", hi, 63 * divs[m]);
            check("mode period", hi + lo, 64 * divs[m]);
        end
        wr(fan_pwm_pkg::ADDR_DUTY, 32'h0000_0082);   // duty 1, select 1
        measure(hi, lo);
        check("duty one high", hi, 11);
        check("duty one low", lo, 63 * 11);
        $display("test modes done");
    endtask : testModes

    task automatic testAlarm;
        int n;
        wr(fan_pwm_pkg::ADDR_SLOWCFG, 32'h1);         // use the pin
        wr(fan_pwm_pkg::ADDR_CTRL, 32'h0000_0000);    // divisor 1
        wr(fan_pwm_pkg::ADDR_EVEN, 32'h3);
        wr(fan_pwm_pkg::ADDR_IRQEN, 32'h1);
        wr(fan_pwm_pkg::ADDR_PRELOAD, 32'h0000_00B8);
        n = 0;
        while (irq !== 1'b1 && n < 200) begin @(posedge refClk); n++; end
        check("alarm in time", n < 200, 1'b1);
        check("wake out", wakeEventOut, 1'b1);
        check("mgmt out", mgmtInterruptOut, 1'b1);
        apb(fan_pwm_pkg::ADDR_COUNT, 1'b0, 32'h0);
        check("count at alarm", rdata >= 32'hC0 && rdata <= 32'hC3, 1);
        apb(fan_pwm_pkg::ADDR_STATUS, 1'b0, 32'h0);
        check("status alarm", rdata, 32'h0000_0001);
        wr(fan_pwm_pkg::ADDR_CLEAR, 32'h1);
        waitCycles(2);
        check("irq cleared", irq, 1'b0);
        check("wake cleared", wakeEventOut, 1'b0);
        check("mgmt cleared", mgmtInterruptOut, 1'b0);
        waitCycles(700);
        apb(fan_pwm_pkg::ADDR_COUNT, 1'b0, 32'h0);
        check("count top", rdata, 32'h0000_00FF);
        waitCycles(100);
        apb(fan_pwm_pkg::ADDR_COUNT, 1'b0, 32'h0);
        check("count held", rdata, 32'h0000_00FF);
        apb(fan_pwm_pkg::ADDR_STATUS, 1'b0, 32'h0);
        check("status sat", rdata, 32'h0000_0002);
        check("irq masked", irq, 1'b0);
        wr(fan_pwm_pkg::ADDR_IRQEN, 32'h2);
        waitCycles(2);
        check("irq unmasked", irq, 1'b1);
        wr(fan_pwm_pkg::ADDR_CLEAR, 32'h3);
        waitCycles(2);
        check("irq off", irq, 1'b0);
        $display("test alarm done");
    endtask : testAlarm

    // a spinning fan keeps the count far below its free-run value
    task automatic testRestart;
        halfPeriod <= 16'h00C8;
        spin       <= 1'b1;
        wr(fan_pwm_pkg::ADDR_PRELOAD, 32'h0000_0020);
        waitCycles(2000);
        apb(fan_pwm_pkg::ADDR_COUNT, 1'b0, 32'h0);
        check("count restarted", rdata >= 32'h20 && rdata <= 32'h54, 1);
        apb(fan_pwm_pkg::ADDR_STATUS, 1'b0, 32'h0);
        check("no alarm", rdata, 32'h0000_0000);
        spin <= 1'b0;
        $display("test restart done");
    endtask : testRestart

    task automatic testDivisor;
        int e;
        for (int k = 0; k < 4; k++) begin
            wr(fan_pwm_pkg::ADDR_CTRL, 32'(k << 4));
            wr(fan_pwm_pkg::ADDR_PRELOAD, 32'h0000_0000);
            waitCycles(640);
            apb(fan_pwm_pkg::ADDR_COUNT, 1'b0, 32'h0);
            e = 80 >> k;
            check("divided count", rdata >= e - 2 && rdata <= e + 2, 1);
        end
        $display("test divisor done");
    endtask : testDivisor

    // ***********************************************************
    // main sequence
    // ***********************************************************
    initial begin
        num_errors = 0; samples_checked = 0; cycles = 0; slowDiv = 3'h0;
        rstn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
        paddr = 12'h000; pwdata = 32'h0000_0000; slowClockPin = 1'b0;
        spin = 1'b0; halfPeriod = 16'h0100;
        waitCycles(2);
        rstn <= 1'b1;
        @(posedge refClk);
        testReset();
        testLevels();
        testModes();
        testAlarm();
        testRestart();
        testDivisor();
        results();
    end
endmodule : tb_top
